// ==== shared/tlta_pkg.sv ====
// Constants for the TLB test access block: coprocessor encodings, field layouts,
// array geometry and reset values. Shared by the design and the bench.
package tlta_pkg;
   localparam int TLB_ENTRIES = 64;
   localparam int IDX_W = 6;
   // Coprocessor instruction fields
   localparam logic [2:0] OP1_STD = 3'h0;
   localparam logic [2:0] OP1_TEST = 3'h4;
   localparam logic [2:0] OP1_ALT = 3'h5;
   localparam logic [3:0] CRN_TBASE = 4'h2;
   localparam logic [3:0] CRN_DAC = 4'h3;
   localparam logic [3:0] CRN_FSTAT = 4'h5;
   localparam logic [3:0] CRN_INV = 4'h8;
   localparam logic [3:0] CRN_LOCK = 4'hA;
   localparam logic [3:0] CRN_TEST = 4'hF;
   localparam logic [3:0] CRM_C0 = 4'h0;
   localparam logic [3:0] CRM_I = 4'h1;
   localparam logic [3:0] CRM_D = 4'h2;
   localparam logic [3:0] CRM_PT_BOTH = 4'h3;
   localparam logic [3:0] CRM_TAG_I = 4'h5;
   localparam logic [3:0] CRM_TAG_D = 4'h6;
   localparam logic [3:0] CRM_TAG_BOTH = 4'h7;
   localparam logic [3:0] CRM_PROT_I = 4'h9;
   localparam logic [3:0] CRM_PROT_D = 4'hA;
   localparam logic [3:0] CRM_PROT_BOTH = 4'hB;
   localparam logic [3:0] CRM_MATCH_I = 4'hD;
   localparam logic [3:0] CRM_MATCH_D = 4'hE;
   localparam logic [2:0] OP2_0 = 3'h0;
   localparam logic [2:0] OP2_1 = 3'h1;
   localparam logic [2:0] OP2_TBASE = 3'h2;
   localparam logic [2:0] OP2_DAC = 3'h3;
   localparam logic [2:0] OP2_RD = 3'h4;
   localparam logic [2:0] OP2_PT_RD = 3'h5;
   localparam logic [2:0] OP2_HOLD = 3'h6;
   // Test status register MMU test bit
   localparam int MMU_TEST_BIT = 3;
   // Tag layout
   localparam int TAG_MSB = 31;
   localparam int TAG_LSB = 10;
   localparam int SIZE_MSB = 9;
   localparam int SIZE_LSB = 6;
   localparam int VALID_BIT = 5;
   localparam int PRES_BIT = 4;
   localparam logic [3:0] SZ_1M = 4'hF;
   localparam logic [3:0] SZ_64K = 4'h7;
   localparam logic [3:0] SZ_16K = 4'h3;
   localparam logic [3:0] SZ_4K = 4'h1;
   localparam logic [3:0] SZ_1K = 4'h0;
   // Protection layout: selector in [3:0], domain/attributes above
   localparam int SEL_MSB = 3;
   localparam int PROT_KEEP_LSB = 4;
   // Match result flags
   localparam int MISS_BIT = 31;
   localparam int PFAULT_BIT = 30;
   // Lockdown layout
   localparam int LK_BASE_LSB = 26;
   localparam int LK_VICT_LSB = 20;
   localparam int LK_PRES_BIT = 0;
   localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
endpackage

// ==== rtl/tlta_core.sv ====
// TLB test access: coprocessor write/read decode, tag, protection and
// physical-tag arrays, result holds, victim pointers, table base, domain,
// fault status and lockdown registers for both TLBs.
// Assumes one coprocessor operation per strobe, synchronous to clk_sys_in.
// How it works
// R1 - Read and probe operations fill result hold
// R2 - 32-bit holds read at c15 c1/c2 op6
// R3 - Test bit: pointer steps on tag/protection access
// R4 - Otherwise step only after protection write
// R5 - Probe miss only reported, no table walk
// R6 - Combined encoding writes both TLBs together
// R7 - Tag word: tag, size, valid, preserve, zeros
// R8 - Size codes 1111/0111/0011/0001/0000 decoded
// R9 - One-hot selector maps to two-bit permission
// R10 - Tag array opcodes c5/c6/c7 decoded
// R11 - Protection opcodes c9/c10/c11 decoded
// R12 - Physical-tag opcodes c1/c2/c3 decoded
// R13 - Probe uses c14 data, c13 instruction
// R14 - Shared base/domain writes both, reads data
// R15 - Invalidate all, per TLB or single entry
// R16 - Lockdown carries victim, base, preserve bit
// R17 - Fault status c5 and alternate prefetch path
// R18 - Read operands are zero by software
// R19 - Software loads victim before array access
// R20 - Hold keeps value until next same-TLB read
// R21 - Combined write uses same operand and stepping
`timescale 1ns/1ps
`default_nettype none
module tlta_core
   import tlta_pkg::*;
(
   input wire logic clk_sys_in, // 200 MHz core clock
   input wire logic nrst_in, // Synchronous reset, active low
   input wire logic wr_stb_in, // Coprocessor write instruction strobe
   input wire logic rd_stb_in, // Coprocessor read instruction strobe
   input wire logic [2:0] opc1_in, // Opcode1
   input wire logic [3:0] crn_in, // CRn
   input wire logic [3:0] crm_in, // CRm
   input wire logic [2:0] opc2_in, // Opcode2
   input wire logic [31:0] wdata_in, // Operand from core
   input wire logic [31:0] test_status_in, // Test status register contents
   output logic [31:0] rdata_out, // Read data, cycle after read strobe
   output logic [1:0] d_perm_out, // Decoded permission of data entry at pointer
   output logic [4:0] d_size_kb_log2_out // Decoded data region size, log2 of KB
);
   typedef logic [1:0] tlta_sel_type; // bit0 data, bit1 instruction
   logic [31:0] tag_mem [2][TLB_ENTRIES];
   logic [31:0] prot_mem [2][TLB_ENTRIES];
   logic [31:0] pt_mem [2][TLB_ENTRIES];
   logic [IDX_W-1:0] victim [2];
   logic [IDX_W-1:0] last_idx [2];
   logic [IDX_W-1:0] lk_base [2];
   logic lk_pres [2];
   logic [31:0] hold [2];
   logic [31:0] translation_table_base [2];
   logic [31:0] dac [2];
   logic [31:0] fault_status_reg [2];

   function automatic logic [1:0] sel_to_perm(input logic [3:0] sel);
      logic [1:0] p;
      p = 2'h0;
      unique case (sel)
         4'h8: p = 2'h3;
         4'h4: p = 2'h2;
         4'h2: p = 2'h1;
         default: p = 2'h0;
      endcase
      return p; // R9
   endfunction

   function automatic logic [4:0] size_log2(input logic [3:0] code);
      logic [4:0] s;
      s = 5'h00;
      unique case (code)
         SZ_1M: s = 5'h0A;
         SZ_64K: s = 5'h06;
         SZ_16K: s = 5'h04;
         SZ_4K: s = 5'h02;
         default: s = 5'h00;
      endcase
      return s; // R8
   endfunction

   // Which TLBs an array opcode targets; a both-code of c0 marks an operation with no
   // combined form, so a stray c0 encoding is refused instead of hitting both TLBs
   function automatic tlta_sel_type tsel(input logic [3:0] crm, input logic [3:0] ci,
                                         input logic [3:0] cd, input logic [3:0] cb);
      return {crm == ci || (cb != CRM_C0 && crm == cb), crm == cd || (cb != CRM_C0 && crm == cb)};
   endfunction

   wire logic t15 = wr_stb_in && opc1_in == OP1_TEST && crn_in == CRN_TEST;
   wire logic w_op0 = t15 && opc2_in == OP2_0;
   wire logic r_op4 = t15 && opc2_in == OP2_RD;
   wire tlta_sel_type tag_wr = w_op0 ? tsel(crm_in, CRM_TAG_I, CRM_TAG_D, CRM_TAG_BOTH) : 2'h0; // R10 R6
   wire tlta_sel_type tag_rd = r_op4 ? tsel(crm_in, CRM_TAG_I, CRM_TAG_D, 4'h0) : 2'h0; // R10
   wire tlta_sel_type prot_wr = w_op0 ? tsel(crm_in, CRM_PROT_I, CRM_PROT_D, CRM_PROT_BOTH) : 2'h0; // R11 R6
   wire tlta_sel_type prot_rd = r_op4 ? tsel(crm_in, CRM_PROT_I, CRM_PROT_D, 4'h0) : 2'h0; // R11
   wire tlta_sel_type pt_wr = (t15 && opc2_in == OP2_1) ?
                              tsel(crm_in, CRM_I, CRM_D, CRM_PT_BOTH) : 2'h0; // R12 R6
   wire tlta_sel_type pt_rd = (t15 && opc2_in == OP2_PT_RD) ? tsel(crm_in, CRM_I, CRM_D, 4'h0) : 2'h0; // R12
   wire tlta_sel_type probe = r_op4 ? tsel(crm_in, CRM_MATCH_I, CRM_MATCH_D, 4'h0) : 2'h0; // R13
   wire logic std = wr_stb_in && opc1_in == OP1_STD;
   wire logic alt = wr_stb_in && opc1_in == OP1_ALT && crn_in == CRN_TEST;
   wire logic std_base = std && crn_in == CRN_TBASE;
   wire tlta_sel_type tbase_wr = {std_base || (alt && crm_in == CRM_I && opc2_in == OP2_TBASE),
                                  std_base || (alt && crm_in == CRM_D && opc2_in == OP2_TBASE)}; // R14
   wire tlta_sel_type dac_wr = {(std && crn_in == CRN_DAC) || (alt && crm_in == CRM_I && opc2_in == OP2_DAC),
                                (std && crn_in == CRN_DAC) || (alt && crm_in == CRM_D && opc2_in == OP2_DAC)}; // R14
   wire tlta_sel_type fstat_wr = {(std && crn_in == CRN_FSTAT && opc2_in == OP2_1) ||
                                  (alt && crm_in == CRM_I && opc2_in == OP2_PT_RD),
                                  std && crn_in == CRN_FSTAT && opc2_in == OP2_0}; // R17
   wire tlta_sel_type lk_wr = {std && crn_in == CRN_LOCK && opc2_in == OP2_1,
                               std && crn_in == CRN_LOCK && opc2_in == OP2_0}; // R16
   wire logic inv = std && crn_in == CRN_INV;
   wire tlta_sel_type inv_all = (inv && opc2_in == OP2_0) ?
                                tsel(crm_in, CRM_TAG_I, CRM_TAG_D, CRM_TAG_BOTH) : 2'h0; // R15
   wire tlta_sel_type inv_one = (inv && opc2_in == OP2_1) ? tsel(crm_in, CRM_TAG_I, CRM_TAG_D, 4'h0) : 2'h0; // R15
   wire logic mmu_test = test_status_in[MMU_TEST_BIT];

   // Read mux, registered so data stand in the cycle after the strobe
   logic [31:0] next_rdata;
   always_comb
   begin
      next_rdata = ZERO_WORD;
      if (rd_stb_in && opc1_in == OP1_STD)
      begin
         unique case (crn_in)
            CRN_TBASE: next_rdata = translation_table_base[0]; // R14
            CRN_DAC: next_rdata = dac[0]; // R14
            CRN_FSTAT: next_rdata = fault_status_reg[opc2_in == OP2_1]; // R17
            CRN_LOCK: next_rdata = {lk_base[opc2_in == OP2_1], victim[opc2_in == OP2_1],
                                    {(LK_VICT_LSB-1){1'b0}}, lk_pres[opc2_in == OP2_1]}; // R16
            default: next_rdata = ZERO_WORD;
         endcase
      end
      else if (rd_stb_in && opc1_in == OP1_TEST && crn_in == CRN_TEST && opc2_in == OP2_HOLD)
      begin
         if (crm_in == CRM_I)
            next_rdata = hold[1]; // R2
         else if (crm_in == CRM_D)
            next_rdata = hold[0]; // R2
      end
      else if (rd_stb_in && opc1_in == OP1_ALT && crn_in == CRN_TEST && crm_in == CRM_I)
      begin
         if (opc2_in == OP2_TBASE)
            next_rdata = translation_table_base[1]; // R14
         else if (opc2_in == OP2_DAC)
            next_rdata = dac[1]; // R14
         else if (opc2_in == OP2_PT_RD)
            next_rdata = fault_status_reg[1]; // R17
      end
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (!nrst_in)
         rdata_out <= ZERO_WORD;
      else
         rdata_out <= next_rdata;
   end

   // Per-TLB state; index 0 is the data TLB, 1 the instruction TLB
   for (genvar t = 0; t < 2; t++)
   begin : g_tlb
      wire logic [IDX_W-1:0] vp = victim[t];
      wire logic tag_acc = tag_wr[t] || tag_rd[t];
      wire logic prot_acc = prot_wr[t] || prot_rd[t];
      wire logic step = mmu_test ? (tag_acc || prot_acc) : prot_wr[t]; // R3 R4 R21
      logic hit;
      logic [IDX_W-1:0] hit_idx;
      logic [IDX_W-1:0] inv_idx;
      logic inv_hit;
      always_comb
      begin
         hit = 1'b0;
         hit_idx = '0;
         inv_hit = 1'b0;
         inv_idx = '0;
         for (int e = 0; e < TLB_ENTRIES; e++)
         begin
            if (tag_mem[t][e][VALID_BIT] && tag_mem[t][e][TAG_MSB:TAG_LSB] == wdata_in[TAG_MSB:TAG_LSB])
            begin
               if (!hit)
                  hit_idx = IDX_W'(e);
               hit = 1'b1;
               if (!inv_hit)
                  inv_idx = IDX_W'(e);
               inv_hit = 1'b1;
            end
         end
      end
      // Probe result: miss flag only, never a walk; otherwise the protection word
      wire logic [31:0] probe_res = hit ?
                                    {1'b0, prot_mem[t][hit_idx][PFAULT_BIT:0]} :
                                    (32'h1 << MISS_BIT); // R5 R13
      always_ff @(posedge clk_sys_in)
      begin
         if (!nrst_in)
         begin
            victim[t] <= '0;
            last_idx[t] <= '0;
            lk_base[t] <= '0;
            lk_pres[t] <= 1'b0;
            hold[t] <= ZERO_WORD;
            translation_table_base[t] <= ZERO_WORD;
            dac[t] <= ZERO_WORD;
            fault_status_reg[t] <= ZERO_WORD;
         end
         else
         begin
            if (lk_wr[t])
            begin
               victim[t] <= wdata_in[LK_BASE_LSB-1:LK_VICT_LSB]; // R16
               lk_base[t] <= wdata_in[31:LK_BASE_LSB];
               lk_pres[t] <= wdata_in[LK_PRES_BIT];
            end
            else if (step)
               victim[t] <= vp + 1'b1; // R3 R4
            if (tag_acc || prot_acc)
               last_idx[t] <= vp; // R19
            if (tag_rd[t])
               hold[t] <= tag_mem[t][vp]; // R1 R20
            else if (prot_rd[t])
               hold[t] <= prot_mem[t][vp]; // R1
            else if (pt_rd[t])
               hold[t] <= pt_mem[t][last_idx[t]]; // R1
            else if (probe[t])
               hold[t] <= probe_res; // R1 R5
            if (tbase_wr[t])
               translation_table_base[t] <= wdata_in; // R14
            if (dac_wr[t])
               dac[t] <= wdata_in; // R14
            if (fstat_wr[t])
               fault_status_reg[t] <= wdata_in; // R17
         end
      end
      // Arrays carry no reset; invalidation clears the valid flag only
      always_ff @(posedge clk_sys_in)
      begin
         if (tag_wr[t])
            tag_mem[t][vp] <= {wdata_in[TAG_MSB:PRES_BIT], 4'h0}; // R7 R21
         if (prot_wr[t])
            prot_mem[t][vp] <= {wdata_in[31:PROT_KEEP_LSB], 2'h0, sel_to_perm(wdata_in[SEL_MSB:0])}; // R9
         if (pt_wr[t])
            pt_mem[t][last_idx[t]] <= wdata_in; // R12
         for (int e = 0; e < TLB_ENTRIES; e++)
         begin
            // Preserved entries survive an invalidate-all
            if (inv_all[t] && !tag_mem[t][e][PRES_BIT])
               tag_mem[t][e][VALID_BIT] <= 1'b0; // R15
         end
         if (inv_one[t] && inv_hit)
            tag_mem[t][inv_idx][VALID_BIT] <= 1'b0; // R15
      end
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (!nrst_in)
      begin
         d_perm_out <= 2'h0;
         d_size_kb_log2_out <= 5'h00;
      end
      else
      begin
         d_perm_out <= prot_mem[0][victim[0]][1:0];
         d_size_kb_log2_out <= size_log2(tag_mem[0][victim[0]][SIZE_MSB:SIZE_LSB]); // R8
      end
   end

   a_hold_tag_read: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // R1
      tag_rd[0] |=> hold[0] == $past(tag_mem[0][victim[0]])) else $error("data hold not loaded");
   a_step_test: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // R3
      (mmu_test && tag_rd[0] && !lk_wr[0]) |=> victim[0] == $past(victim[0]) + 1'b1)
      else $error("pointer did not step in test mode");
   a_step_norm: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // R4
      (!mmu_test && !prot_wr[0] && !lk_wr[0]) |=> $stable(victim[0])) else $error("pointer moved");
   a_miss_flag: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // R5
      (probe[1] && !g_tlb[1].hit) |=> hold[1][MISS_BIT]) else $error("miss not reported");
   a_both_write: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // R6
      (w_op0 && crm_in == CRM_TAG_BOTH) |-> tag_wr == 2'h3) else $error("combined write not both");
   a_hold_keep: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // R20
      !(tag_rd[1] || prot_rd[1] || pt_rd[1] || probe[1]) |=> $stable(hold[1])) else $error("hold changed");
   a_shared_base: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // R14
      std_base |=> translation_table_base[0] == translation_table_base[1]) else $error("base copies differ");
   a_read_data: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // R2
      (rd_stb_in && opc1_in == OP1_TEST && crn_in == CRN_TEST && crm_in == CRM_D && opc2_in == OP2_HOLD)
      |=> rdata_out == $past(hold[0])) else $error("hold read wrong");
   a_perm_map: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // R9
      (prot_wr[0] && wdata_in[SEL_MSB:0] == 4'h4) |=> prot_mem[0][$past(victim[0])][1:0] == 2'h2)
      else $error("permission map wrong");
   a_tag_low_zero: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // R7
      tag_wr[0] |=> tag_mem[0][$past(victim[0])][PRES_BIT-1:0] == 4'h0) else $error("tag low bits kept");
   a_lock_load: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // R16
      lk_wr[1] |=> victim[1] == $past(wdata_in[LK_BASE_LSB-1:LK_VICT_LSB])) else $error("victim not loaded");
   a_inv_entry: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // R15
      (inv_one[0] && g_tlb[0].inv_hit) |=> !tag_mem[0][$past(g_tlb[0].inv_idx)][VALID_BIT])
      else $error("entry still valid");
   c_probe_hit: cover property (@(posedge clk_sys_in) probe[0] && g_tlb[0].hit);
   c_probe_miss: cover property (@(posedge clk_sys_in) probe[1] && !g_tlb[1].hit);
   c_both_prot: cover property (@(posedge clk_sys_in) prot_wr == 2'h3);
   c_inv_all: cover property (@(posedge clk_sys_in) inv_all == 2'h3);
endmodule
`default_nettype wire

// ==== tb/tlta_core_model.sv ====
// Core-side model: issues coprocessor write and read instructions to the TLB test block.
// Assumes a free running core clock and a block that never stalls.
`timescale 1ns/1ps
`default_nettype none
module tlta_core_model
(
   input wire logic clk_in, // Core clock
   input wire logic [31:0] rdata_in, // Read data from the block
   output logic wr_stb_out, // Write instruction strobe
   output logic rd_stb_out, // Read instruction strobe
   output logic [2:0] opc1_out, // Opcode1
   output logic [3:0] crn_out, // CRn
   output logic [3:0] crm_out, // CRm
   output logic [2:0] opc2_out, // Opcode2
   output logic [31:0] wdata_out // Operand
);
   initial
   begin
      wr_stb_out = 1'b0;
      rd_stb_out = 1'b0;
      {opc1_out, crn_out, crm_out, opc2_out} = 14'h0000;
      wdata_out = 32'h0000_0000;
   end

   // Operand is inverted once taken so a stale value never passes for a fresh one
   task automatic coproc_write_instr(input logic [13:0] enc, input logic [31:0] d);
      wr_stb_out <= 1'b1;
      {opc1_out, crn_out, crm_out, opc2_out} <= enc;
      wdata_out <= d;
      @(posedge clk_in);
      wr_stb_out <= 1'b0;
      wdata_out <= ~d;
      @(posedge clk_in);
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic coproc_read_instr(input logic [13:0] enc, output logic [31:0] d);
      rd_stb_out <= 1'b1;
      {opc1_out, crn_out, crm_out, opc2_out} <= enc;
      @(posedge clk_in);
      rd_stb_out <= 1'b0;
      @(posedge clk_in);
      d = rdata_in;
   endtask
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the TLB test access block: drives coprocessor
// instructions through the core model and compares read-backs.
// Assumes tlta_pkg, the block and the core model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import tlta_pkg::*;
;
   logic clk_sys_in, nrst_in;
   logic [31:0] tstat;
   logic wr_stb, rd_stb;
   logic [2:0] opc1, opc2;
   logic [3:0] crn, crm;
   logic [31:0] wdata, rdata;
   logic [1:0] d_perm;
   logic [4:0] d_size;
   int error_cnt = 0;
   int samples_checked = 0;
   localparam logic [13:0] TW_D = {OP1_TEST, CRN_TEST, CRM_TAG_D, OP2_0},
      TW_B = {OP1_TEST, CRN_TEST, CRM_TAG_BOTH, OP2_0}, TR_D = {OP1_TEST, CRN_TEST, CRM_TAG_D, OP2_RD},
      TR_I = {OP1_TEST, CRN_TEST, CRM_TAG_I, OP2_RD}, PW_D = {OP1_TEST, CRN_TEST, CRM_PROT_D, OP2_0},
      PW_B = {OP1_TEST, CRN_TEST, CRM_PROT_BOTH, OP2_0}, PR_D = {OP1_TEST, CRN_TEST, CRM_PROT_D, OP2_RD},
      XW_D = {OP1_TEST, CRN_TEST, CRM_D, OP2_1}, XR_D = {OP1_TEST, CRN_TEST, CRM_D, OP2_PT_RD},
      MT_D = {OP1_TEST, CRN_TEST, CRM_MATCH_D, OP2_RD}, MT_I = {OP1_TEST, CRN_TEST, CRM_MATCH_I, OP2_RD},
      HD = {OP1_TEST, CRN_TEST, CRM_D, OP2_HOLD}, HI = {OP1_TEST, CRN_TEST, CRM_I, OP2_HOLD},
      LK_D = {OP1_STD, CRN_LOCK, CRM_C0, OP2_0}, LK_I = {OP1_STD, CRN_LOCK, CRM_C0, OP2_1},
      INV_ALL = {OP1_STD, CRN_INV, CRM_TAG_BOTH, OP2_0}, INV_I = {OP1_STD, CRN_INV, CRM_TAG_I, OP2_0},
      INV_DE = {OP1_STD, CRN_INV, CRM_TAG_D, OP2_1}, FST_D = {OP1_STD, CRN_FSTAT, CRM_C0, OP2_0},
      FST_I = {OP1_STD, CRN_FSTAT, CRM_C0, OP2_1}, FST_IA = {OP1_ALT, CRN_TEST, CRM_I, OP2_PT_RD},
      UNMAP = 14'h3FFF;
   localparam logic [13:0] SH [2] = '{{OP1_STD, CRN_TBASE, CRM_C0, OP2_0}, {OP1_STD, CRN_DAC, CRM_C0, OP2_0}};
   localparam logic [13:0] IA [2] = '{{OP1_ALT, CRN_TEST, CRM_I, OP2_TBASE}, {OP1_ALT, CRN_TEST, CRM_I, OP2_DAC}};
   localparam logic [13:0] DA [2] = '{{OP1_ALT, CRN_TEST, CRM_D, OP2_TBASE}, {OP1_ALT, CRN_TEST, CRM_D, OP2_DAC}};
   localparam logic [3:0] SZC [5] = '{SZ_1M, SZ_64K, SZ_16K, SZ_4K, SZ_1K};
   localparam logic [4:0] SZL [5] = '{5'h0A, 5'h06, 5'h04, 5'h02, 5'h00};
   localparam logic [31:0] TAGW = 32'h0AAA_A820;

   tlta_core i_tlta_core (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .wr_stb_in(wr_stb), .rd_stb_in(rd_stb),
      .opc1_in(opc1), .crn_in(crn), .crm_in(crm), .opc2_in(opc2), .wdata_in(wdata), .test_status_in(tstat),
      .rdata_out(rdata), .d_perm_out(d_perm), .d_size_kb_log2_out(d_size));
   tlta_core_model i_tlta_core_model (.clk_in(clk_sys_in), .rdata_in(rdata), .wr_stb_out(wr_stb),
      .rd_stb_out(rd_stb), .opc1_out(opc1), .crn_out(crn), .crm_out(crm), .opc2_out(opc2), .wdata_out(wdata));

   initial
   begin
      clk_sys_in = 1'b0;
      forever #2.5 clk_sys_in = ~clk_sys_in;
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic rd(input logic [13:0] enc, input logic [31:0] exp, input string what);
      logic [31:0] d;
      i_tlta_core_model.coproc_read_instr(enc, d);
      chk(what, exp, d);
   endtask

   task automatic wr(input logic [13:0] enc, input logic [31:0] d);
      i_tlta_core_model.coproc_write_instr(enc, d);
   endtask

   task automatic wrap_up;
      $display("Checks made %0d, mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial
   begin
      tstat = 32'h0000_0000;
      nrst_in = 1'b0;
      repeat (12) @(posedge clk_sys_in);
      nrst_in <= 1'b1;
      @(posedge clk_sys_in);
      rd(HD, ZERO_WORD, "data hold after reset");
      rd(UNMAP, ZERO_WORD, "unmapped read");
      wr(INV_ALL, ZERO_WORD);
      wr(LK_D, 32'h0050_0000);
      wr(TW_D, 32'hFEDC_B5AF);
      wr(TR_D, ZERO_WORD);
      rd(HD, 32'hFEDC_B5A0, "data hold tag");
      rd(HI, ZERO_WORD, "instr hold untouched");
      rd(LK_D, 32'h0050_0000, "victim after tag access");
      for (int k = 0; k < 4; k++)
      begin
         wr(LK_D, 32'h0050_0000);
         wr(PW_D, 32'hABCD_EF00 | (32'h8 >> k));
         rd(LK_D, 32'h0060_0000, "victim after prot write");
         wr(LK_D, 32'h0050_0000);
         @(posedge clk_sys_in);
         chk("permission", {30'h0, 2'(3 - k)}, {30'h0, d_perm});
      end
      wr(PR_D, ZERO_WORD);
      rd(HD, 32'hABCD_EF00, "prot read");
      for (int k = 0; k < 5; k++)
      begin
         wr(LK_D, 32'h0070_0000);
         wr(TW_D, {22'h0, SZC[k], 6'h00});
         @(posedge clk_sys_in);
         chk("region size", {27'h0, SZL[k]}, {27'h0, d_size});
      end
      // Test bit set: every tag or protection access steps the pointer
      tstat <= 32'h1 << MMU_TEST_BIT;
      wr(LK_D, 32'h00A0_0000);
      wr(TR_D, ZERO_WORD);
      wr(TW_D, ZERO_WORD);
      wr(PR_D, ZERO_WORD);
      rd(LK_D, 32'h00D0_0000, "victim with test bit");
      tstat <= ZERO_WORD;
      wr(LK_D, 32'h01E0_0000);
      wr(LK_I, 32'h01E0_0000);
      wr(TW_B, TAGW);
      wr(TR_D, ZERO_WORD);
      rd(HD, TAGW, "combined tag data side");
      wr(TR_I, ZERO_WORD);
      rd(HI, TAGW, "combined tag instr side");
      wr(PW_B, 32'h1234_5678);
      rd(LK_D, 32'h01F0_0000, "data victim after combined");
      rd(LK_I, 32'h01F0_0000, "instr victim after combined");
      wr(XW_D, 32'h5555_5180);
      wr(XR_D, ZERO_WORD);
      rd(HD, 32'h5555_5180, "phys tag read");
      wr(MT_D, 32'h0AAA_A800);
      rd(HD, 32'h1234_5673, "probe hit");
      wr(MT_I, 32'h1555_5000);
      rd(HI, 32'h8000_0000, "probe miss");
      wr(INV_DE, 32'h0AAA_A800);
      wr(MT_D, 32'h0AAA_A800);
      rd(HD, 32'h8000_0000, "probe after entry invalidate");
      wr({OP1_TEST, CRN_TEST, CRM_C0, OP2_RD}, ZERO_WORD);
      rd(HD, 32'h8000_0000, "hold after unmapped op");
      wr(INV_I, ZERO_WORD);
      wr(MT_I, 32'h0AAA_A800);
      rd(HI, 32'h8000_0000, "probe after instr invalidate");
      for (int k = 0; k < 2; k++)
      begin
         wr(SH[k], 32'h0000_4000 + k);
         rd(IA[k], 32'h0000_4000 + k, "instr copy of shared write");
         wr(DA[k], 32'h0000_8000 + k);
         rd(SH[k], 32'h0000_8000 + k, "shared read gives data copy");
         rd(IA[k], 32'h0000_4000 + k, "instr copy kept");
      end
      wr(FST_I, 32'h0000_00F5);
      wr(FST_D, 32'h0000_0005);
      rd(FST_IA, 32'h0000_00F5, "prefetch fault alternate");
      rd(FST_D, 32'h0000_0005, "data fault");
      rd(HI, 32'h8000_0000, "instr hold kept");
      // Mid-run reset must clear pointers and holds again
      nrst_in <= 1'b0;
      repeat (2) @(posedge clk_sys_in);
      nrst_in <= 1'b1;
      @(posedge clk_sys_in);
      rd(LK_I, ZERO_WORD, "instr lockdown after reset");
      rd(HI, ZERO_WORD, "instr hold after reset");
      wrap_up();
   end

   initial
   begin
      repeat (20000) @(posedge clk_sys_in);
      error_cnt++;
      $display("CHECK FAILED watchdog expected finish seen timeout");
      wrap_up();
   end
endmodule
`default_nettype wire
